// File: acf_pkg.sv
/*
  Package for the converter control and result formatter block.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
`default_nettype none

package acf_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] RAW_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] MASK_OFS   = 8'h10;

  // control field positions
  localparam int ON_BIT      = 15;
  localparam int IDLE_BIT    = 13;
  localparam int FORM_LSB    = 8;
  localparam int TRIG_LSB    = 4;
  localparam int RES_BIT     = 3;
  localparam int AUTO_BIT    = 2;
  localparam int SAMPLE_CONTROL_BIT    = 1;
  localparam int DONE_BIT    = 0;

  // writable control bits; everything else reads zero
  localparam logic [31:0] CTRL_WMASK = 32'h0000_A7FF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_OVR  = 1;
  localparam logic [1:0] ST_RESET = 2'h0;

  // conversion length in clocks
  localparam logic [4:0] CONV_CYCLES = 5'h0E;
  localparam logic [4:0] SAMPLE_CONTROL_CYCLES = 5'h04;

  // output format codes
  typedef enum logic [2:0] {
    FMT_UINT16  = 3'h0,
    FMT_SINT16  = 3'h1,
    FMT_UFRAC16 = 3'h2,
    FMT_SFRAC16 = 3'h3,
    FMT_UINT32  = 3'h4,
    FMT_SINT32  = 3'h5,
    FMT_UFRAC32 = 3'h6,
    FMT_SFRAC32 = 3'h7
  } acf_fmt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE_CONTROL = 3'b010,
    ST_CONV = 3'b100
  } acf_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } acf_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } acf_apb_rsp_t;

endpackage

`default_nettype wire

// File: acf_ctrl.sv
/*
  Converter control register, sample/convert sequencer and result formatter.
  Assumes an APB master on clock_i, an analog core that delivers a raw
  12-bit code on sample_code_i, and device idle and trigger levels from pins.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - converter runs only while the module enable bit 15 is set
// - idle stop bit 13 set halts the converter while device idles
// - resolution bit picks 12-bit results when 1, 10-bit when 0
// - format field bits 10..8 selects packing of the result word
// - code 111: signed fraction, sign at bit 31, low bits zero
// - code 110: unsigned fraction left-justified to bit 31
// - code 101: signed integer, sign extended through bit 31
// - code 100: unsigned integer right-justified, upper bits zero
// - code 011: signed fraction, sign at bit 15, upper half zero
// - code 010: unsigned fraction left-justified to bit 15
// - code 000: unsigned integer right-justified, upper bits zero
// - sample bit held clear and unwritable while module is off
// - in auto mode the done flag clears when next sample begins
// - unimplemented control bits read zero; all fields reset to zero
module acf_ctrl
  import acf_pkg::*;
#(
  parameter int RAW_W = 12
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire acf_apb_req_t     apb_i,
  output var  acf_apb_rsp_t     apb_o,
  input  wire logic             dev_idle_i,
  input  wire logic             ext_trigger_i,
  input  wire logic [RAW_W-1:0] sample_code_i,
  output logic                  converting_o,
  output logic                  irq_o
);

  typedef struct packed {
    logic [1:0]       idle_sync;
    logic [1:0]       trig_sync;
    logic             trig_prev;
    logic [31:0]      ctrl;
    logic [31:0]      result;
    logic [RAW_W-1:0] raw;
    logic [1:0]       status;
    logic [1:0]       mask;
    acf_phase_t       phase;
    logic [4:0]       count;
    acf_apb_rsp_t     rsp;
    logic             converting;
    logic             irq;
  } acf_state_t;

  acf_state_t st;
  acf_state_t next_st;

  // pack a raw code per format and resolution
  function automatic logic [31:0] pack_result(input logic [RAW_W-1:0] raw,
                                              input logic [2:0] form,
                                              input logic resolution_select);
    logic [11:0] d;
    logic [31:0] u;
    logic [31:0] s;
    logic [31:0] o;
    d = resolution_select ? raw[11:0] : {2'h0, raw[11:2]};
    u = {20'h0, d};
    s = resolution_select ? {{20{d[11]}}, d} : {{22{d[9]}}, d[9:0]};
    o = 32'h0;
    unique case (acf_fmt_t'(form))
      FMT_UINT16:  o = u;
      FMT_SINT16:  o = {16'h0, s[15:0]};
      FMT_UFRAC16: o = resolution_select ? {16'h0, d, 4'h0} : {16'h0, d[9:0], 6'h0};
      FMT_SFRAC16: o = resolution_select ? {16'h0, d, 4'h0} : {16'h0, d[9:0], 6'h0};
      FMT_UINT32:  o = u;
      FMT_SINT32:  o = s;
      FMT_UFRAC32: o = resolution_select ? {d, 20'h0} : {d[9:0], 22'h0};
      FMT_SFRAC32: o = resolution_select ? {d, 20'h0} : {d[9:0], 22'h0};
    endcase
    return o;
  endfunction

  logic        acc;
  logic        wr;
  logic        rd;
  logic        on;
  logic        run;
  logic        trig_edge;
  logic [31:0] wval;
  logic [31:0] rval;

  always_comb begin
    next_st = st;
    acc = apb_i.psel && apb_i.penable;
    wr = acc && apb_i.pwrite;
    rd = acc && !apb_i.pwrite;
    on = st.ctrl[ON_BIT];
    // halted when off or idling with stop set
    run = on && !(st.ctrl[IDLE_BIT] && st.idle_sync[1]);
    next_st.idle_sync = {st.idle_sync[0], dev_idle_i};
    next_st.trig_sync = {st.trig_sync[0], ext_trigger_i};
    next_st.trig_prev = st.trig_sync[1];
    trig_edge = st.trig_sync[1] && !st.trig_prev;
    wval = apb_i.pwdata & CTRL_WMASK;

    rval = 32'h0;
    unique case (apb_i.paddr)
      CTRL_OFS:   rval = st.ctrl;
      RESULT_OFS: rval = st.result;
      RAW_OFS:    rval = {{(32-RAW_W){1'b0}}, st.raw};
      STATUS_OFS: rval = {30'h0, st.status};
      MASK_OFS:   rval = {30'h0, st.mask};
      default:    rval = 32'h0;
    endcase
    next_st.rsp.pready = acc && !st.rsp.pready;
    next_st.rsp.prdata = (rd && !st.rsp.pready) ? rval : 32'h0;
    next_st.rsp.pslverr = 1'b0;
    if (acc && !st.rsp.pready) begin
      unique case (apb_i.paddr)
        CTRL_OFS, RESULT_OFS, RAW_OFS, STATUS_OFS, MASK_OFS: ;
        default: next_st.rsp.pslverr = 1'b1;
      endcase
    end

    if (wr && !st.rsp.pready && apb_i.paddr == CTRL_OFS) begin
      next_st.ctrl = wval;
    end
    if (wr && !st.rsp.pready && apb_i.paddr == MASK_OFS) begin
      next_st.mask = apb_i.pwdata[1:0];
    end
    // status clears on read
    if (rd && !st.rsp.pready && apb_i.paddr == STATUS_OFS) begin
      next_st.status = ST_RESET;
    end

    unique case (st.phase)
      ST_IDLE: begin
        if (run && (next_st.ctrl[SAMPLE_CONTROL_BIT] || next_st.ctrl[AUTO_BIT])) begin
          next_st.phase = ST_SAMPLE_CONTROL;
          next_st.count = SAMPLE_CONTROL_CYCLES;
          next_st.ctrl[SAMPLE_CONTROL_BIT] = 1'b1;
          // done cleared at start of sample in auto mode only
          if (next_st.ctrl[AUTO_BIT]) begin
            next_st.ctrl[DONE_BIT] = 1'b0;
          end
        end
      end
      ST_SAMPLE_CONTROL: begin
        if (!run) begin
          next_st.phase = ST_IDLE;
        end else if (st.count != 5'h0) begin
          next_st.count = st.count - 5'h1;
        end else if (!next_st.ctrl[SAMPLE_CONTROL_BIT] || next_st.ctrl[AUTO_BIT]
                     || (next_st.ctrl[TRIG_LSB +: 4] != 4'h0 && trig_edge)) begin
          next_st.phase = ST_CONV;
          next_st.count = CONV_CYCLES;
          next_st.ctrl[SAMPLE_CONTROL_BIT] = 1'b0;
        end
      end
      ST_CONV: begin
        if (!run) begin
          next_st.phase = ST_IDLE;
        end else if (st.count != 5'h0) begin
          next_st.count = st.count - 5'h1;
        end else begin
          next_st.phase = ST_IDLE;
          next_st.raw = sample_code_i;
          next_st.result = pack_result(sample_code_i, st.ctrl[FORM_LSB +: 3],
                                       st.ctrl[RES_BIT]);
          next_st.ctrl[DONE_BIT] = 1'b1;
          next_st.status[ST_OVR] = st.status[ST_OVR] | st.ctrl[DONE_BIT];
          next_st.status[ST_DONE] = 1'b1;
        end
      end
      default: next_st.phase = ST_IDLE;
    endcase

    // sample bit forced clear when off
    if (!next_st.ctrl[ON_BIT]) begin
      next_st.ctrl[SAMPLE_CONTROL_BIT] = 1'b0;
    end
    next_st.converting = (next_st.phase == ST_CONV);
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.phase <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign apb_o = st.rsp;
  assign converting_o = st.converting;
  assign irq_o = st.irq;

endmodule

`default_nettype wire

// File: acf_sva.sv
/*
  Checker for the converter control block: bus timing, read masks, run rules.
  Assumes it is bound to acf_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module acf_sva
  import acf_pkg::*;
(
  input wire logic         clock_i,
  input wire logic         nrst_i,
  input wire acf_apb_req_t apb_i,
  input wire acf_apb_rsp_t apb_o,
  input wire logic         dev_idle_i,
  input wire logic         converting_o,
  input wire logic         irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [31:0] ctl;
  logic [1:0]  msk;
  wire logic   acc = apb_i.psel && apb_i.penable && !apb_o.pready;
  wire logic   rd  = apb_o.pready && !apb_i.pwrite;
  wire logic   rdc = rd && apb_i.paddr == CTRL_OFS;
  // shadow of software writes
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ctl <= 32'h0;
      msk <= 2'h0;
    end else if (acc && apb_i.pwrite) begin
      if (apb_i.paddr == CTRL_OFS) ctl <= apb_i.pwdata;
      if (apb_i.paddr == MASK_OFS) msk <= apb_i.pwdata[1:0];
    end
  end
  sequence acc_s;
    acc ##1 apb_o.pready;
  endsequence
  sequence conv_s;
    converting_o [*8] ##[6:8] !converting_o;
  endsequence
  ready_wait_a: assert property (acc |-> acc_s) else $error("no ready");
  ready_pulse_a: assert property (apb_o.pready |=> !apb_o.pready) else $error("long ready");
  ctrl_zero_a: assert property (rdc |-> (apb_o.prdata & ~CTRL_WMASK) == 32'h0)
    else $error("reserved bits set");
  off_sample_a: assert property (rdc && !apb_o.prdata[ON_BIT] |-> !apb_o.prdata[SAMPLE_CONTROL_BIT])
    else $error("sample bit while off");
  bad_addr_a: assert property (rd && apb_i.paddr > MASK_OFS |-> apb_o.pslverr && apb_o.prdata == 32'h0)
    else $error("unmapped read");
  off_run_a: assert property ((!ctl[ON_BIT]) [*2] |-> !converting_o) else $error("runs while off");
  idle_stop_a: assert property ((ctl[IDLE_BIT] && dev_idle_i) [*4] |-> !$rose(converting_o))
    else $error("runs while idle");
  conv_len_a: assert property ($rose(converting_o) |-> conv_s) else $error("conversion length");
  irq_mask_a: assert property ((msk == 2'h0) [*2] |-> !irq_o) else $error("masked irq");
endmodule
`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for acf_ctrl: registers, format codes, irq, idle stop.
  Assumes acf_pkg and acf_sva are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acf_pkg::*;
  logic         clock_i = 1'h0;
  logic         nrst_i = 1'h0;
  logic         dev_idle_i = 1'h0;
  logic         converting_o;
  logic         irq_o;
  logic [11:0]  code = 12'h0;
  acf_apb_req_t apb_i = '0;
  acf_apb_rsp_t apb_o;
  logic [32:0]  exp_q[$];
  int           err_count = 0;
  int           comparisons = 0;
  acf_ctrl u_acf_ctrl (.clock_i, .nrst_i, .apb_i, .apb_o, .dev_idle_i,
    .ext_trigger_i(1'h0), .sample_code_i(code), .converting_o, .irq_o);
  initial forever #12.5 clock_i = ~clock_i;
  task automatic stop_test();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bail();
    err_count++;
    stop_test();
  endtask
  task automatic chk_rd(logic [32:0] got, logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    int n;
    @(posedge clock_i);
    if (!wr) exp_q.push_back(e);
    apb_i <= '{1'h1, 1'h0, wr, a, d};
    @(posedge clock_i);
    apb_i.penable <= 1'h1;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (apb_o.pready !== 1'h1 && n < 20);
    @(posedge clock_i);
    apb_i.psel <= 1'h0;
    apb_i.penable <= 1'h0;
    if (n >= 20) bail();
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'h1 && n < 60) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 60) bail();
  endtask
  function automatic logic [31:0] fmt(logic [2:0] f, logic r, logic [11:0] c);
    logic [31:0] u;
    logic [31:0] s;
    int          w;
    w = r ? 12 : 10;
    u = r ? 32'(c) : 32'(c >> 2);
    s = u[w-1] ? u | (32'hFFFF_FFFF << w) : u;
    case (f)
      3'h1: return s & 32'h0000_FFFF;
      3'h2, 3'h3: return u << (16 - w);
      3'h5: return s;
      3'h6, 3'h7: return u << (32 - w);
      default: return u;
    endcase
  endfunction
  always @(negedge clock_i) begin
    if (apb_o.pready === 1'h1 && apb_i.pwrite === 1'h0) begin
      chk_rd({apb_o.pslverr, apb_o.prdata}, exp_q.pop_front());
    end
  end
  initial begin
    logic [31:0] cv;
    void'($urandom(68));
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'h1;
    apb(1'h0, CTRL_OFS, 32'h0, 33'h0);
    apb(1'h0, 8'h14, 32'h0, 33'h1_0000_0000);
    apb(1'h1, CTRL_OFS, 32'hFFFF_7FFE, 33'h0);
    apb(1'h0, CTRL_OFS, 32'h0, 33'h0_0000_27FC);
    chk_rd({32'h0, converting_o}, 33'h0);
    apb(1'h1, MASK_OFS, 32'h1, 33'h0);
    for (int i = 0; i < 16; i++) begin
      cv = 32'h8000 | (32'(i[2:0]) << FORM_LSB) | (32'(i[3]) << RES_BIT);
      code <= 12'($urandom);
      apb(1'h1, CTRL_OFS, cv | 32'h2, 33'h0);
      repeat (6) @(posedge clock_i);
      apb(1'h1, CTRL_OFS, cv, 33'h0);
      wait_hi(irq_o);
      apb(1'h0, RESULT_OFS, 32'h0, {1'h0, fmt(i[2:0], i[3], code)});
      apb(1'h0, RAW_OFS, 32'h0, {21'h0, code});
      apb(1'h0, STATUS_OFS, 32'h0, 33'h1);
      repeat (2) @(posedge clock_i);
      chk_rd({32'h0, irq_o}, 33'h0);
    end
    dev_idle_i <= 1'h1;
    apb(1'h1, CTRL_OFS, 32'hA004, 33'h0);
    repeat (40) @(posedge clock_i);
    chk_rd({32'h0, converting_o}, 33'h0);
    dev_idle_i <= 1'h0;
    wait_hi(converting_o);
    wait_hi(irq_o);
    apb(1'h1, CTRL_OFS, 32'h0, 33'h0);
    stop_test();
  end
endmodule
bind acf_ctrl acf_sva u_acf_sva (.clock_i, .nrst_i, .apb_i, .apb_o, .dev_idle_i,
  .converting_o, .irq_o);
`default_nettype wire
